// ### hdl/pwr_pkg.sv
// Purpose: shared constants and carriers for the switch power mode controller
// Assumes: 100 MHz ref_clk
// Notes: mode codes follow the two-bit mode field
package pwr_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_ENERGY = 2'h1,
      MODE_SOFT_PD = 2'h2,
      MODE_SAVING = 2'h3
   } mode_t;

   localparam int NUM_PORTS = 4;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [7:0] SLEEP_RESET = 8'h00;
   localparam logic [NUM_PORTS-1:0] PORT_PD_RESET = 4'h0;
   // field positions of the mode register image
   localparam int MODE_LSB = 3;
   localparam int MODE_MSB = 4;

   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_WIDTH_NS = 120;
   localparam int PULSE_CYCLES = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_PERIOD_S = 1;
   localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_S * 100_000_000;
   // one idle-delay step; each count of the sleep field is this many milliseconds
   localparam int SLEEP_STEP_MS = 1;
   localparam int SLEEP_STEP_CYCLES = SLEEP_STEP_MS * 100_000;

   typedef struct packed {
      logic clk_en;
      logic mac_en;
      logic host_en;
      logic tx_en;
      logic rx_full_en;
      logic energy_det_en;
   } power_ctl_t;

   typedef struct packed {
      logic wr;
      logic [1:0] mode;
      logic [7:0] sleep_time;
      logic [NUM_PORTS-1:0] port_pd;
   } host_wr_t;
endpackage : pwr_pkg

// ### hdl/tick_counter.sv
// Purpose: free counter that pulses when it reaches one below its terminal count
// Assumes: clear held whenever counting must restart
// Notes: terminal given as a 32-bit value
`timescale 1ns/100ps
module tick_counter
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clear,
   input wire logic [31:0] terminal,
   output logic tick
);
   logic [31:0] count;
   wire at_end = (count >= terminal - 32'h1);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         count <= 32'h0;
      else if (clear || at_end)
         count <= 32'h0;
      else
         count <= count + 32'h1;
   end

   assign tick = at_end && !clear;
endmodule // tick_counter

// ### hdl/power_mode_ctrl.sv
// Purpose: power mode controller for a four port switch
// Assumes: cable_energy is an asynchronous pin level; host access is same-domain
// Notes: long counts are top parameters so a simulation can shorten them
// Operation
// - mode field: normal, energy, soft down, saving
// - per-port bit powers down that port
// - reset loads normal mode
// - normal keeps clocks, phy, mac, host on
// - host write from normal changes mode
// - energy sleep/soft disable clocks, mac, host
// - no cable in energy mode sleeps automatically
// - energy mode emits 120 ns pulse per second
// - sleep after idle exceeds sleep field
// - low power keeps only energy detect; port power still follows port_pd
// - cable energy wakes to normal power
// - soft down kills clocks, phys, macs
// - host access in soft down resets registers
// - saving keeps tx, drops unused rx
`timescale 1ns/100ps
module power_mode_ctrl #(
   parameter int PULSE_PERIOD = pwr_pkg::PULSE_PERIOD_CYCLES,
   parameter int SLEEP_STEP = pwr_pkg::SLEEP_STEP_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire pwr_pkg::host_wr_t host_wr,
   input wire logic host_access,
   input wire logic cable_energy,
   output pwr_pkg::mode_t mode,
   output logic [7:0] sleep_time,
   output logic [pwr_pkg::NUM_PORTS-1:0] port_pd,
   output pwr_pkg::power_ctl_t power_ctl,
   output logic [pwr_pkg::NUM_PORTS-1:0] port_power_en,
   output logic low_power,
   output logic link_pulse,
   output logic soft_reset
);
   typedef enum logic [2:0] {
      ST_AWAKE = 3'h1,
      ST_ASLEEP = 3'h2,
      ST_WAKING = 3'h4
   } ed_state_t;

   ed_state_t state;
   ed_state_t next_state;
   logic energy_meta;
   logic energy;
   logic [8:0] idle_steps;
   logic [7:0] pulse_cnt;
   logic pulse_run;
   logic step_tick;
   logic sec_tick;

   // two-flop synchroniser; only the second stage is used
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         energy_meta <= 1'b0;
         energy <= 1'b0;
      end
      else
      begin
         energy_meta <= cable_energy;
         energy <= energy_meta;
      end
   end

   wire in_energy = (mode == pwr_pkg::MODE_ENERGY);
   wire in_soft = (mode == pwr_pkg::MODE_SOFT_PD);
   wire in_saving = (mode == pwr_pkg::MODE_SAVING);
   wire host_live = !(in_soft || (in_energy && state != ST_AWAKE));
   // host writes only count while the host interface is powered
   wire wr_ok = host_wr.wr && host_live;
   // any access while soft powered down acts as a wake and internal reset
   wire wake_reset = in_soft && (host_access || host_wr.wr);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode <= pwr_pkg::mode_t'(pwr_pkg::MODE_RESET);
         sleep_time <= pwr_pkg::SLEEP_RESET;
         port_pd <= pwr_pkg::PORT_PD_RESET;
      end
      else if (wake_reset)
      begin
         mode <= pwr_pkg::mode_t'(pwr_pkg::MODE_RESET);
         sleep_time <= pwr_pkg::SLEEP_RESET;
         port_pd <= pwr_pkg::PORT_PD_RESET;
      end
      else if (wr_ok)
      begin
         mode <= pwr_pkg::mode_t'(host_wr.mode);
         sleep_time <= host_wr.sleep_time;
         port_pd <= host_wr.port_pd;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         soft_reset <= 1'b0;
      else
         soft_reset <= wake_reset;
   end

   // idle timer counts sleep-field steps with no cable energy
   tick_counter step_timer (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clear(energy || !in_energy || state != ST_AWAKE),
      .terminal(32'(SLEEP_STEP)),
      .tick(step_tick)
   );

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         idle_steps <= 9'h000;
      else if (energy || !in_energy || state != ST_AWAKE)
         idle_steps <= 9'h000;
      else if (step_tick && idle_steps <= {1'b0, sleep_time})
         idle_steps <= idle_steps + 9'h001;
   end

   // strictly longer than the programmed delay
   wire idle_expired = (idle_steps > {1'b0, sleep_time});

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_AWAKE:
            if (in_energy && idle_expired)
               next_state = ST_ASLEEP;
         ST_ASLEEP:
            if (!in_energy)
               next_state = ST_AWAKE;
            else if (energy)
               next_state = ST_WAKING;
         ST_WAKING:
            next_state = ST_AWAKE;
         default:
            next_state = ST_AWAKE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         state <= ST_AWAKE;
      else
         state <= next_state;
   end

   // beacon: one fixed-width pulse per second while energy detect is selected
   tick_counter sec_timer (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clear(!in_energy),
      .terminal(32'(PULSE_PERIOD)),
      .tick(sec_tick)
   );

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pulse_cnt <= 8'h00;
         pulse_run <= 1'b0;
      end
      else if (!in_energy)
      begin
         pulse_cnt <= 8'h00;
         pulse_run <= 1'b0;
      end
      else if (sec_tick)
      begin
         pulse_cnt <= 8'h01;
         pulse_run <= 1'b1;
      end
      else if (pulse_run && pulse_cnt == 8'(pwr_pkg::PULSE_CYCLES))
      begin
         pulse_cnt <= 8'h00;
         pulse_run <= 1'b0;
      end
      else if (pulse_run)
         pulse_cnt <= pulse_cnt + 8'h01;
   end

   assign link_pulse = pulse_run;

   // enables per mode; energy detect awake state runs fully so packets can pass
   wire ed_asleep = in_energy && (state != ST_AWAKE);
   assign low_power = ed_asleep;
   assign power_ctl.clk_en = !(in_soft || ed_asleep);
   assign power_ctl.mac_en = !(in_soft || ed_asleep);
   assign power_ctl.host_en = host_live;
   assign power_ctl.tx_en = !(in_soft || ed_asleep);
   assign power_ctl.rx_full_en = !(in_soft || ed_asleep) && !(in_saving && !energy);
   assign power_ctl.energy_det_en = in_energy || in_saving;
   // per-port down applies in every mode; soft power-down also turns every port off
   assign port_power_en = {pwr_pkg::NUM_PORTS{!in_soft}} & ~port_pd;

   // helper counters: long holds are judged on a count, not a long repetition
   logic [7:0] pulse_len;
   logic [31:0] quiet_len;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         pulse_len <= 8'h00;
      else if (link_pulse)
         pulse_len <= pulse_len + 8'h01;
      else
         pulse_len <= 8'h00;
   end

   // quiet cable cycles while energy detect is awake
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         quiet_len <= 32'h0;
      else if (energy || !in_energy || low_power)
         quiet_len <= 32'h0;
      else
         quiet_len <= quiet_len + 32'h1;
   end

   // reset, mode register and host writes
   a_reset_normal: assert property (@(posedge ref_clk)
      $rose(rstn) |-> mode == pwr_pkg::MODE_NORMAL)
      else $error("mode not normal after reset");
   a_write_mode: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mode == pwr_pkg::MODE_NORMAL && host_wr.wr) |=> mode == $past(host_wr.mode))
      else $error("mode write lost");
   a_mode_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!host_wr.wr && !host_access) |=> mode == $past(mode))
      else $error("mode changed without host action");
   a_normal_on: assert property (@(posedge ref_clk) disable iff (!rstn)
      mode == pwr_pkg::MODE_NORMAL |-> (power_ctl.clk_en && power_ctl.host_en && power_ctl.mac_en))
      else $error("normal mode not fully powered");
   a_ports_normal: assert property (@(posedge ref_clk) disable iff (!rstn)
      mode == pwr_pkg::MODE_NORMAL |-> port_power_en == ~port_pd)
      else $error("port power enables wrong in normal mode");
   a_port_down: assert property (@(posedge ref_clk) disable iff (!rstn)
      port_pd[0] |-> !port_power_en[0])
      else $error("port power-down ignored");

   // soft power-down
   a_soft_off: assert property (@(posedge ref_clk) disable iff (!rstn)
      in_soft |-> !(power_ctl.clk_en || power_ctl.mac_en || power_ctl.tx_en || |port_power_en))
      else $error("soft power-down left blocks on");
   a_soft_host_off: assert property (@(posedge ref_clk) disable iff (!rstn)
      in_soft |-> !power_ctl.host_en)
      else $error("soft power-down left host on");
   a_soft_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
      (in_soft && host_access) |=> (mode == pwr_pkg::MODE_NORMAL && soft_reset))
      else $error("soft power-down did not wake on access");
   a_soft_write_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
      (in_soft && host_wr.wr) |=> (mode == pwr_pkg::MODE_NORMAL && soft_reset))
      else $error("soft power-down did not wake on write");
   a_soft_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
      soft_reset |=> !soft_reset)
      else $error("internal reset longer than one cycle");
   a_wake_host_on: assert property (@(posedge ref_clk) disable iff (!rstn)
      soft_reset |-> (mode == pwr_pkg::MODE_NORMAL && power_ctl.host_en))
      else $error("wake did not restore normal mode");

   // energy detect, sleep and beacon
   a_sleep_enter: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state == ST_AWAKE && in_energy && idle_expired) |=> low_power)
      else $error("did not sleep after idle");
   a_sleep_delay: assert property (@(posedge ref_clk) disable iff (!rstn)
      ($rose(low_power) && in_energy) |->
         (quiet_len > 32'(sleep_time) * 32'(SLEEP_STEP)
         && quiet_len <= (32'(sleep_time) + 32'h2) * 32'(SLEEP_STEP)))
      else $error("sleep entered outside the idle delay");
   a_sleep_off: assert property (@(posedge ref_clk) disable iff (!rstn)
      low_power |-> power_ctl == 6'h01)
      else $error("low power state left blocks on");
   a_refuse_asleep: assert property (@(posedge ref_clk) disable iff (!rstn)
      (low_power && host_wr.wr) |=> mode == $past(mode))
      else $error("write taken while host interface off");
   a_wake_energy: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state == ST_ASLEEP && in_energy && energy && !host_wr.wr) |-> ##2 !low_power)
      else $error("did not wake on energy");
   a_energy_awake_on: assert property (@(posedge ref_clk) disable iff (!rstn)
      (in_energy && !low_power) |-> (power_ctl.clk_en && power_ctl.mac_en && power_ctl.tx_en))
      else $error("energy detect awake state not powered");
   a_pulse_width: assert property (@(posedge ref_clk) disable iff (!rstn)
      ($fell(link_pulse) && in_energy) |-> pulse_len == 8'(pwr_pkg::PULSE_CYCLES))
      else $error("beacon pulse width wrong");
   a_beacon_off: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!in_energy && !$past(in_energy)) |-> !link_pulse)
      else $error("beacon outside energy detect");

   // power saving
   a_saving_tx: assert property (@(posedge ref_clk) disable iff (!rstn)
      in_saving |-> (power_ctl.tx_en && power_ctl.host_en))
      else $error("power saving dropped tx or host");
   a_saving_rx: assert property (@(posedge ref_clk) disable iff (!rstn)
      in_saving |-> power_ctl.rx_full_en == energy)
      else $error("power saving receiver does not follow cable");
endmodule // power_mode_ctrl

// ### sim/testbench.sv
// Purpose: self-checking bench for the switch power mode controller
// Assumes: short beacon period and sleep step so a run stays brief
// Notes: inputs change by non-blocking assignment on the rising edge, outputs sampled at negedge
`timescale 1ns/100ps
module testbench;
   localparam int PERIOD = 100;
   localparam int STEP = 4;
   logic ref_clk;
   logic rstn;
   logic host_access;
   logic cable_energy;
   pwr_pkg::host_wr_t host_wr;
   pwr_pkg::mode_t mode;
   logic [7:0] sleep_time;
   logic [pwr_pkg::NUM_PORTS-1:0] port_pd;
   logic [pwr_pkg::NUM_PORTS-1:0] port_power_en;
   pwr_pkg::power_ctl_t power_ctl;
   logic low_power;
   logic link_pulse;
   logic soft_reset;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;

   power_mode_ctrl #(.PULSE_PERIOD(PERIOD), .SLEEP_STEP(STEP)) power_mode_ctrl_i
   (
      .ref_clk(ref_clk), .rstn(rstn), .host_wr(host_wr), .host_access(host_access),
      .cable_energy(cable_energy), .mode(mode), .sleep_time(sleep_time), .port_pd(port_pd),
      .power_ctl(power_ctl), .port_power_en(port_power_en), .low_power(low_power),
      .link_pulse(link_pulse), .soft_reset(soft_reset)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one strobe carries all fields together
   task automatic host_write(input logic [1:0] m, input logic [7:0] s, input logic [3:0] p);
      @(posedge ref_clk);
      host_wr <= '{1'b1, m, s, p};
      @(posedge ref_clk);
      host_wr.wr <= 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic test_reset();
      @(negedge ref_clk);
      chk("mode", 16'(mode), 16'h0000);
      chk("power_ctl", 16'(power_ctl), 16'h003E);
      chk("port_pd", 16'(port_pd), 16'h0000);
      chk("soft_reset", 16'(soft_reset), 16'h0000);
   endtask

   task automatic test_port_pd();
      host_write(2'h0, 8'h00, 4'h5);
      chk("port_pd", 16'(port_pd), 16'h0005);
      chk("port_power_en", 16'(port_power_en), 16'h000A);
      chk("mode", 16'(mode), 16'h0000);
      host_write(2'h0, 8'h00, 4'h0);
   endtask

   task automatic test_saving();
      host_write(2'h3, 8'h00, 4'h0);
      chk("mode", 16'(mode), 16'h0003);
      chk("clk mac host tx", 16'(power_ctl[5:2]), 16'h000F);
      chk("rx_full_en", 16'(power_ctl.rx_full_en), 16'h0001);
      @(posedge ref_clk);
      cable_energy <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("rx_full_en", 16'(power_ctl.rx_full_en), 16'h0000);
      @(posedge ref_clk);
      cable_energy <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("rx_full_en", 16'(power_ctl.rx_full_en), 16'h0001);
      host_write(2'h0, 8'h00, 4'h0);
      chk("mode", 16'(mode), 16'h0000);
   endtask

   task automatic test_soft();
      host_write(2'h2, 8'h33, 4'h3);
      chk("mode", 16'(mode), 16'h0002);
      chk("sleep_time", 16'(sleep_time), 16'h0033);
      chk("clk mac host", 16'(power_ctl[5:3]), 16'h0000);
      chk("port_power_en", 16'(port_power_en), 16'h0000);
      @(posedge ref_clk);
      host_access <= 1'b1;
      @(posedge ref_clk);
      host_access <= 1'b0;
      @(negedge ref_clk);
      chk("mode", 16'(mode), 16'h0000);
      chk("soft_reset", 16'(soft_reset), 16'h0001);
      chk("sleep_time", 16'(sleep_time), 16'h0000);
      chk("port_pd", 16'(port_pd), 16'h0000);
      @(negedge ref_clk);
      chk("soft_reset", 16'(soft_reset), 16'h0000);
      // a write in soft power-down only wakes; its data is dropped
      host_write(2'h2, 8'h00, 4'h0);
      host_write(2'h3, 8'h11, 4'h1);
      chk("mode", 16'(mode), 16'h0000);
      chk("soft_reset", 16'(soft_reset), 16'h0001);
      chk("port_pd", 16'(port_pd), 16'h0000);
   endtask

   task automatic test_energy();
      int n;
      int highs;
      n = 0;
      highs = 0;
      @(posedge ref_clk);
      cable_energy <= 1'b0;
      host_write(2'h1, 8'h02, 4'h0);
      chk("mode", 16'(mode), 16'h0001);
      // idle must exceed two full steps of four cycles before sleeping
      repeat (8) @(negedge ref_clk);
      chk("early low_power", 16'(low_power), 16'h0000);
      while (low_power !== 1'b1 && n < 40)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk("low_power", 16'(low_power), 16'h0001);
      chk("clk mac host", 16'(power_ctl[5:3]), 16'h0000);
      chk("energy_det_en", 16'(power_ctl.energy_det_en), 16'h0001);
      chk("power_ctl", 16'(power_ctl), 16'h0001);
      // host interface is off while asleep, so this write must be ignored
      host_write(2'h0, 8'h00, 4'h0);
      chk("mode", 16'(mode), 16'h0001);
      chk("low_power", 16'(low_power), 16'h0001);
      // any window of two periods holds exactly 24 high cycles, the width of two 12-cycle pulses
      repeat (2 * PERIOD)
      begin
         @(negedge ref_clk);
         highs += int'(link_pulse === 1'b1);
      end
      chk("pulse cycles", 16'(highs), 16'(2 * pwr_pkg::PULSE_CYCLES));
      @(posedge ref_clk);
      cable_energy <= 1'b1;
      n = 0;
      while (low_power !== 1'b0 && n < 10)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk("low_power", 16'(low_power), 16'h0000);
      chk("clk_en", 16'(power_ctl.clk_en), 16'h0001);
      host_write(2'h0, 8'h00, 4'h0);
   endtask

   // a hang costs a mismatch instead of a stuck run
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         final_report();
      end
   end

   initial
   begin
      rstn = 1'b0;
      host_wr = '0;
      host_access = 1'b0;
      cable_energy = 1'b1;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      test_reset();
      test_port_pd();
      test_saving();
      test_soft();
      test_energy();
      final_report();
   end
endmodule // testbench
